//--- rtl/channel_linking_tx_repeat.sv
// Purpose: Timer channel 1 linking and serial transmit with bit repeat
// Assumes: Pads are asynchronous; the bit clock is a free running port
// Notes:   Link outputs lag the pad by the two synchroniser stages and the output register
`timescale 1ns/10ps
module channel_linking_tx_repeat (
  // Core clock and reset
  input  wire logic                               core_clk_i,
  input  wire logic                               rst_b_i,
  // Link clock
  input  wire logic                               serial_bit_clk_i,
  // Channel link control
  input  wire logic                               timer_chan_link_enable_i,
  input  wire logic                               first_chan_is_output_i,
  input  wire logic                               second_chan_is_output_i,
  // Timer unit outputs
  input  wire logic                               first_timer_unit_channel1_i,
  input  wire logic                               second_timer_unit_channel1_i,
  // Timer unit inputs
  output logic                                    first_chan_in_o,
  output logic                                    second_chan_in_o,
  // First channel pad
  input  wire logic                               first_pad_i,
  output logic                                    first_pad_o,
  output logic                                    first_pad_oe_o,
  // Second channel pad
  input  wire logic                               second_pad_i,
  output logic                                    second_pad_o,
  output logic                                    second_pad_oe_o,
  // Link status
  output chan_link_pkg::link_mode_t               link_mode_o,
  // Transmit request
  input  wire logic [chan_link_pkg::WORD_W-1:0]   tx_word_i,
  input  wire logic [chan_link_pkg::REP_W-1:0]    transmit_repeat_register_i,
  input  wire logic                               tx_load_i,
  output logic                                    tx_ready_o,
  // Transmit status
  output logic                                    tx_busy_o,
  output logic                                    tx_done_o,
  output logic                                    tx_overrun_o,
  input  wire logic                               tx_overrun_clr_i,
  output logic [chan_link_pkg::SENT_W-1:0]        tx_sent_count_o,
  // Serial line
  output logic                                    serial_tx_o,
  output logic                                    serial_frame_o
);

  typedef struct packed {
    logic                               first_in;
    logic                               second_in;
    logic                               first_pad;
    logic                               first_oe;
    logic                               second_pad;
    logic                               second_oe;
    chan_link_pkg::link_mode_t          mode;
    logic [chan_link_pkg::WORD_W-1:0]   word;
    logic                               req;
    logic                               busy;
    logic                               done;
    logic                               overrun;
    logic [chan_link_pkg::SENT_W-1:0]   sent;
  } core_st_t;

  core_st_t   st_reg;
  core_st_t   st_next;
  logic [1:0] pad_sync;
  logic       ack_sync;
  logic       first_pad_s;
  logic       second_pad_s;
  logic       load_ok;

  tx_xfer_if xfer ();

  // Pads come from outside the core clock domain
  bit_sync #(.WIDTH(2)) u_pad_sync (
    .clk_i   (core_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({second_pad_i, first_pad_i}),
    .q_o     (pad_sync)
  );

  bit_sync #(.WIDTH(1)) u_ack_sync (
    .clk_i   (core_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (xfer.ack_tgl),
    .q_o     (ack_sync)
  );

  assign first_pad_s  = pad_sync[0];
  assign second_pad_s = pad_sync[1];

  // A new word is taken only while no transfer is open
  assign load_ok = tx_load_i && !st_reg.busy;

  always_comb begin
    st_next = st_reg;

    // Default: each channel hears its own pad and drives it when output
    st_next.first_in   = first_pad_s;
    st_next.second_in  = second_pad_s;
    st_next.first_pad  = first_timer_unit_channel1_i;
    st_next.first_oe   = first_chan_is_output_i;
    st_next.second_pad = second_timer_unit_channel1_i;
    st_next.second_oe  = second_chan_is_output_i;
    st_next.mode       = chan_link_pkg::LINK_NONE;

    if (timer_chan_link_enable_i) begin
      case ({first_chan_is_output_i, second_chan_is_output_i})
        2'b00: begin
          st_next.first_in  = first_pad_s;
          st_next.second_in = first_pad_s;
          st_next.mode      = chan_link_pkg::LINK_SHARED;
        end
        2'b01: begin
          // Second unit's output value goes straight across
          st_next.first_in = second_timer_unit_channel1_i;
          st_next.mode     = chan_link_pkg::LINK_B_TO_A;
        end
        2'b10: begin
          st_next.second_in = first_timer_unit_channel1_i;
          st_next.mode      = chan_link_pkg::LINK_A_TO_B;
        end
        default: begin
          // Two drivers are never tied together
          st_next.mode = chan_link_pkg::LINK_NONE;
        end
      endcase
    end

    // Transmit side
    st_next.done = 1'b0;
    if (st_reg.busy && (ack_sync == st_reg.req)) begin
      st_next.busy = 1'b0;
      st_next.done = 1'b1;
      st_next.sent = st_reg.sent + chan_link_pkg::SENT_STEP;
    end

    if (load_ok) begin
      // Repeats are folded in here so the link side stays a plain shifter
      st_next.word = chan_link_pkg::repeat_expand(
        tx_word_i, transmit_repeat_register_i);
      st_next.req  = ~st_reg.req;
      st_next.busy = 1'b1;
    end

    // A load refused while busy is remembered; a new one beats the clear
    if (tx_overrun_clr_i) begin
      st_next.overrun = 1'b0;
    end
    if (tx_load_i && st_reg.busy) begin
      st_next.overrun = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg      <= '0;
      st_reg.mode <= chan_link_pkg::LINK_NONE;
      st_reg.word <= chan_link_pkg::WORD_RST;
      st_reg.sent <= chan_link_pkg::SENT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign xfer.req_tgl = st_reg.req;
  assign xfer.word    = st_reg.word;

  tx_serializer u_ser (
    .serial_bit_clk_i (serial_bit_clk_i),
    .rst_b_i          (rst_b_i),
    .xfer             (xfer.link),
    .serial_tx_o      (serial_tx_o),
    .serial_frame_o   (serial_frame_o)
  );

  assign first_chan_in_o  = st_reg.first_in;
  assign second_chan_in_o = st_reg.second_in;
  assign first_pad_o      = st_reg.first_pad;
  assign first_pad_oe_o   = st_reg.first_oe;
  assign second_pad_o     = st_reg.second_pad;
  assign second_pad_oe_o  = st_reg.second_oe;
  assign link_mode_o      = st_reg.mode;
  assign tx_ready_o       = !st_reg.busy;
  assign tx_busy_o        = st_reg.busy;
  assign tx_done_o        = st_reg.done;
  assign tx_overrun_o     = st_reg.overrun;
  assign tx_sent_count_o  = st_reg.sent;

endmodule // channel_linking_tx_repeat

//--- rtl/chan_link_pkg.sv
// Purpose: Shared constants, types and helpers for the channel link block
// Assumes: One 16-bit transmit word, one repeat bit for each odd word bit
// Notes:   All timing is in serial bit clock cycles
package chan_link_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned REP_W  = 8;
  localparam int unsigned CNT_W  = 4;
  localparam int unsigned SENT_W = 8;

  localparam logic [CNT_W-1:0]  FIRST_SLOT   = 4'h0;
  localparam logic [CNT_W-1:0]  LAST_SLOT    = 4'hF;
  localparam logic [CNT_W-1:0]  SLOT_STEP    = 4'h1;
  localparam logic [WORD_W-1:0] WORD_RST     = 16'h0000;
  localparam logic [SENT_W-1:0] SENT_RST     = 8'h00;
  localparam logic [SENT_W-1:0] SENT_STEP    = 8'h01;
  localparam logic              LINE_IDLE    = 1'b0;

  // Link mode seen on the status port
  typedef enum logic [3:0] {
    LINK_NONE   = 4'h1,
    LINK_SHARED = 4'h2,
    LINK_B_TO_A = 4'h4,
    LINK_A_TO_B = 4'h8
  } link_mode_t;

  // Serializer states
  typedef enum logic [1:0] {
    SER_IDLE  = 2'h1,
    SER_SHIFT = 2'h2
  } ser_state_t;

  // Even bit 2k takes the value of bit 2k+1 when repeat bit k is set
  function automatic logic [WORD_W-1:0] repeat_expand(
    input logic [WORD_W-1:0] word,
    input logic [REP_W-1:0]  sel
  );
    logic [WORD_W-1:0] res;
    res = word;
    for (int k = 0; k < REP_W; k++) begin
      if (sel[k]) begin
        res[2*k] = word[2*k+1];
      end
    end
    return res;
  endfunction

endpackage

//--- rtl/tx_xfer_if.sv
// Purpose: Carries one transmit word from the core domain to the link domain
// Assumes: Toggle handshake; word is held while a request is open
// Notes:   Request and acknowledge are toggles, each crossing through two flops
`timescale 1ns/10ps
interface tx_xfer_if;
  logic                                req_tgl;
  logic                                ack_tgl;
  logic [chan_link_pkg::WORD_W-1:0]    word;

  modport core (output req_tgl, output word, input ack_tgl);
  modport link (input req_tgl, input word, output ack_tgl);
endinterface

//--- rtl/bit_sync.sv
// Purpose: Two flip-flop synchroniser for independent level bits
// Assumes: Each bit is a level or a toggle, never a multi-bit value
// Notes:   The first stage is read by the second stage only
`timescale 1ns/10ps
module bit_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next        = st_reg;
    st_next.meta   = d_i;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.stable;

endmodule // bit_sync

//--- rtl/tx_serializer.sv
// Purpose: Shifts a transmit word out on the serial bit clock
// Assumes: The bit clock runs free; the word is held until acknowledged
// Notes:   Repeated bits are already folded into the word by the core side
`timescale 1ns/10ps
module tx_serializer (
  // Link clock and reset
  input  wire logic serial_bit_clk_i,
  input  wire logic rst_b_i,
  // Word handshake
  tx_xfer_if.link   xfer,
  // Serial line
  output logic      serial_tx_o,
  output logic      serial_frame_o
);

  typedef struct packed {
    chan_link_pkg::ser_state_t          state;
    logic [chan_link_pkg::WORD_W-1:0]   shreg;
    logic [chan_link_pkg::CNT_W-1:0]    slot;
    logic                               req_seen;
    logic                               ack;
    logic                               tx;
    logic                               frame;
  } ser_st_t;

  ser_st_t st_reg;
  ser_st_t st_next;
  logic    req_sync;

  bit_sync #(.WIDTH(1)) u_req_sync (
    .clk_i   (serial_bit_clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (xfer.req_tgl),
    .q_o     (req_sync)
  );

  always_comb begin
    st_next = st_reg;
    case (st_reg.state)
      chan_link_pkg::SER_IDLE: begin
        if (req_sync != st_reg.req_seen) begin
          // Word is stable: the core holds it until the ack returns
          st_next.req_seen = req_sync;
          st_next.shreg    = xfer.word;
          st_next.tx       = xfer.word[chan_link_pkg::WORD_W-1];
          st_next.slot     = chan_link_pkg::FIRST_SLOT;
          st_next.frame    = 1'b1;
          st_next.state    = chan_link_pkg::SER_SHIFT;
        end
      end
      chan_link_pkg::SER_SHIFT: begin
        if (st_reg.slot == chan_link_pkg::LAST_SLOT) begin
          st_next.tx    = chan_link_pkg::LINE_IDLE;
          st_next.frame = 1'b0;
          st_next.ack   = ~st_reg.ack;
          st_next.state = chan_link_pkg::SER_IDLE;
        end else begin
          // One bit per bit clock, most significant first
          st_next.shreg = {st_reg.shreg[chan_link_pkg::WORD_W-2:0], 1'b0};
          st_next.tx    = st_reg.shreg[chan_link_pkg::WORD_W-2];
          st_next.slot  = st_reg.slot + chan_link_pkg::SLOT_STEP;
        end
      end
      default: begin
        st_next.state = chan_link_pkg::SER_IDLE;
      end
    endcase
  end

  always_ff @(posedge serial_bit_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg       <= '0;
      st_reg.state <= chan_link_pkg::SER_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign serial_tx_o    = st_reg.tx;
  assign serial_frame_o = st_reg.frame;
  assign xfer.ack_tgl   = st_reg.ack;

endmodule // tx_serializer

//--- test/channel_linking_tx_repeat_properties.sv
// Purpose: Port-level properties of the channel link block
// Assumes: Bound to the top module; input names match its ports
// Notes:   Frame length is counted in helper logic, too long to unroll
`timescale 1ns/10ps
module channel_linking_tx_repeat_properties (
  // Clocks and reset
  input wire logic                 core_clk_i,
  input wire logic                 rst_b_i,
  input wire logic                 serial_bit_clk_i,
  // Channel link
  input wire logic                 timer_chan_link_enable_i,
  input wire logic                 first_chan_is_output_i,
  input wire logic                 second_chan_is_output_i,
  input wire logic                 first_timer_unit_channel1_i,
  input wire logic                 second_timer_unit_channel1_i,
  input wire logic                 first_chan_in_o,
  input wire logic                 second_chan_in_o,
  input chan_link_pkg::link_mode_t link_mode_o,
  // Transmit
  input wire logic                 tx_load_i,
  input wire logic                 tx_busy_o,
  input wire logic                 tx_done_o,
  input wire logic                 serial_tx_o,
  input wire logic                 serial_frame_o
);
  wire logic en = timer_chan_link_enable_i;
  wire logic fo = first_chan_is_output_i;
  wire logic so = second_chan_is_output_i;
  logic [4:0] frame_cnt_reg;
  logic [4:0] frame_cnt_next;

  always_comb frame_cnt_next = serial_frame_o ? frame_cnt_reg + 5'h01 : 5'h00;
  always_ff @(posedge serial_bit_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) frame_cnt_reg <= 5'h00;
    else frame_cnt_reg <= frame_cnt_next;
  end

  shared_link_a: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) en && !fo && !so |=> link_mode_o ==
    chan_link_pkg::LINK_SHARED && first_chan_in_o == second_chan_in_o)
    else $error("shared link mode or inputs differ");
  b_to_a_a: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) en && !fo && so |=> link_mode_o ==
    chan_link_pkg::LINK_B_TO_A &&
    first_chan_in_o == $past(second_timer_unit_channel1_i))
    else $error("second output not routed to first input");
  a_to_b_a: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) en && fo && !so |=> link_mode_o ==
    chan_link_pkg::LINK_A_TO_B &&
    second_chan_in_o == $past(first_timer_unit_channel1_i))
    else $error("first output not routed to second input");
  no_link_a: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    !en || (fo && so) |=> link_mode_o == chan_link_pkg::LINK_NONE)
    else $error("link applied where none is allowed");
  // An unknown frame level before the first reset edge must not count as a fall
  frame_len_a: assert property (@(posedge serial_bit_clk_i)
    disable iff (!rst_b_i) $past(serial_frame_o) && !serial_frame_o |->
    frame_cnt_reg == 5'h10)
    else $error("frame not sixteen bit clocks long");
  idle_line_a: assert property (@(posedge serial_bit_clk_i)
    disable iff (!rst_b_i) !serial_frame_o |-> !serial_tx_o)
    else $error("serial line not low outside frame");
  load_busy_a: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) tx_load_i && !tx_busy_o |=> tx_busy_o)
    else $error("accepted load did not raise busy");
  done_end_a: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i) $fell(tx_busy_o) |-> tx_done_o ##1 !tx_done_o)
    else $error("done not a single pulse at end of busy");

  shared_c: cover property (@(posedge core_clk_i)
    link_mode_o == chan_link_pkg::LINK_SHARED);
  frame_c: cover property (@(posedge serial_bit_clk_i) $fell(serial_frame_o));
  done_c: cover property (@(posedge core_clk_i) tx_done_o);
endmodule // channel_linking_tx_repeat_properties

//--- test/serial_rx_model.sv
// Purpose: Far-side serial receiver that assembles each sent frame
// Assumes: Line sampled on the bit clock edge after the device launches it
// Notes:   A short frame is dropped; only full sixteen-bit words count
`timescale 1ns/10ps
module serial_rx_model (
  input  wire logic bit_clk_i,
  input  wire logic rst_b_i,
  input  wire logic line_i,
  input  wire logic frame_i,
  output logic [15:0] rx_word_o,
  output logic [7:0]  rx_count_o
);
  logic [15:0] shift_reg;
  logic [4:0]  nbits_reg;

  always @(posedge bit_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nbits_reg <= 5'h00;
      rx_word_o <= 16'h0000;
      rx_count_o <= 8'h00;
    end else if (frame_i) begin
      shift_reg <= {shift_reg[14:0], line_i};
      nbits_reg <= nbits_reg + 5'h01;
      if (nbits_reg == 5'h0F) begin
        rx_word_o <= {shift_reg[14:0], line_i};
        rx_count_o <= rx_count_o + 8'h01;
      end
    end else begin
      nbits_reg <= 5'h00;
    end
  end
endmodule // serial_rx_model

//--- test/tb_channel_linking_tx_repeat.sv
// Purpose: Self-checking bench for channel linking and transmit repeat
// Assumes: Pads resolved from enables; bit clock runs free as the design needs
// Notes:   Random link and word traffic from a fixed seed plus corners
`timescale 1ns/10ps
module tb_channel_linking_tx_repeat;
  logic core_clk_i = 1'b0, serial_bit_clk_i = 1'b0, rst_b_i = 1'b0;
  logic timer_chan_link_enable_i = 1'b0, first_chan_is_output_i = 1'b0;
  logic second_chan_is_output_i = 1'b0, tx_load_i = 1'b0;
  logic first_timer_unit_channel1_i = 1'b0, tx_overrun_clr_i = 1'b0;
  logic second_timer_unit_channel1_i = 1'b0, first_ext = 1'b0;
  logic second_ext = 1'b0;
  logic [15:0] tx_word_i = 16'h0000;
  logic [7:0]  transmit_repeat_register_i = 8'h00;
  logic first_chan_in_o, second_chan_in_o, first_pad_o, first_pad_oe_o;
  logic second_pad_o, second_pad_oe_o, tx_ready_o, tx_busy_o, tx_done_o;
  logic tx_overrun_o, serial_tx_o, serial_frame_o;
  logic [7:0]  tx_sent_count_o, rx_count, sent = 8'h00;
  logic [15:0] rx_word;
  chan_link_pkg::link_mode_t link_mode_o;
  int mismatches = 0, n_checks = 0, cycles = 0;
  wire logic first_pad_i = first_pad_oe_o ? first_pad_o : first_ext;
  wire logic second_pad_i = second_pad_oe_o ? second_pad_o : second_ext;

  always #5 core_clk_i = ~core_clk_i;
  always #16 serial_bit_clk_i = ~serial_bit_clk_i;

  channel_linking_tx_repeat i_channel_linking_tx_repeat (.core_clk_i,
    .rst_b_i, .serial_bit_clk_i, .timer_chan_link_enable_i,
    .first_chan_is_output_i, .second_chan_is_output_i,
    .first_timer_unit_channel1_i, .second_timer_unit_channel1_i,
    .first_chan_in_o, .second_chan_in_o, .first_pad_i, .first_pad_o,
    .first_pad_oe_o, .second_pad_i, .second_pad_o, .second_pad_oe_o,
    .link_mode_o, .tx_word_i, .transmit_repeat_register_i, .tx_load_i,
    .tx_ready_o, .tx_busy_o, .tx_done_o, .tx_overrun_o, .tx_overrun_clr_i,
    .tx_sent_count_o, .serial_tx_o, .serial_frame_o);
  serial_rx_model i_serial_rx_model (.bit_clk_i(serial_bit_clk_i),
    .rst_b_i(rst_b_i), .line_i(serial_tx_o), .frame_i(serial_frame_o),
    .rx_word_o(rx_word), .rx_count_o(rx_count));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [5:0] link_exp(input logic [2:0] c);
    logic pa, pb;
    pa = c[1] ? first_timer_unit_channel1_i : first_ext;
    pb = c[0] ? second_timer_unit_channel1_i : second_ext;
    case (c)
      3'b100: return {pa, pa, chan_link_pkg::LINK_SHARED};
      3'b101: return {second_timer_unit_channel1_i, pb,
                      chan_link_pkg::LINK_B_TO_A};
      3'b110: return {pa, first_timer_unit_channel1_i,
                      chan_link_pkg::LINK_A_TO_B};
      default: return {pa, pb, chan_link_pkg::LINK_NONE};
    endcase
  endfunction

  function automatic logic [15:0] exp_word(input logic [15:0] w,
                                           input logic [7:0] s);
    logic [15:0] r;
    r = w;
    for (int k = 0; k < 8; k++) if (s[k]) r[2*k] = w[2*k+1];
    return r;
  endfunction

  // A refused load carries a different word to prove it was ignored
  task automatic send(input logic [15:0] w, input logic [7:0] s,
                      input logic ovr);
    while (tx_ready_o !== 1'b1) @(negedge core_clk_i);
    {tx_word_i, transmit_repeat_register_i, tx_load_i} = {w, s, 1'b1};
    @(negedge core_clk_i);
    {tx_word_i, tx_load_i} = {~w, ovr};
    chk({tx_busy_o, tx_ready_o}, 2'b10);
    @(negedge core_clk_i);
    tx_load_i = 1'b0;
    while (tx_done_o !== 1'b1) @(negedge core_clk_i);
    sent++;
    chk(rx_word, exp_word(w, s));
    chk({rx_count, tx_sent_count_o}, {sent, sent});
    chk(tx_overrun_o, ovr);
    tx_overrun_clr_i = 1'b1;
    @(negedge core_clk_i);
    tx_overrun_clr_i = 1'b0;
  endtask

  initial begin
    void'($urandom(32'h353F59ED));
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_b_i = 1'b1;
    for (int i = 0; i < 24; i++) begin
      {timer_chan_link_enable_i, first_chan_is_output_i,
       second_chan_is_output_i} = i[2:0];
      {first_timer_unit_channel1_i, second_timer_unit_channel1_i,
       first_ext, second_ext} = 4'($urandom);
      repeat (6) @(negedge core_clk_i);
      chk({first_chan_in_o, second_chan_in_o, link_mode_o},
          link_exp(i[2:0]));
      chk({first_pad_oe_o, first_pad_o, second_pad_oe_o, second_pad_o},
          {i[1], first_timer_unit_channel1_i, i[0],
           second_timer_unit_channel1_i});
    end
    send(16'hAAAA, 8'hFF, 1'b0);
    send(16'h5555, 8'hFF, 1'b1);
    send(16'h8000, 8'h80, 1'b0);
    send(16'h0002, 8'h01, 1'b1);
    send(16'hFFFE, 8'h00, 1'b0);
    for (int i = 0; i < 12; i++)
      send(16'($urandom), 8'($urandom), 1'($urandom));
    tally_and_finish();
  end

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
endmodule // tb_channel_linking_tx_repeat

bind channel_linking_tx_repeat channel_linking_tx_repeat_properties i_props (
  .core_clk_i, .rst_b_i, .serial_bit_clk_i, .timer_chan_link_enable_i,
  .first_chan_is_output_i, .second_chan_is_output_i,
  .first_timer_unit_channel1_i, .second_timer_unit_channel1_i,
  .first_chan_in_o, .second_chan_in_o, .link_mode_o, .tx_load_i,
  .tx_busy_o, .tx_done_o, .serial_tx_o, .serial_frame_o);
